// ==== src/bmr_map.vh ====
`ifndef BMR_MAP_VH
`define BMR_MAP_VH
// Modbus function codes handled by the register map.
`define BMR_FC_READ_HOLD 8'h03
`define BMR_FC_READ_INPUT 8'h04
`define BMR_FC_WRITE_COIL 8'h05
`define BMR_FC_WRITE_HOLD 8'h06
`define BMR_FC_EXC_FLAG 8'h80
// Standard exception codes.
`define BMR_EXC_FUNC 8'h01
`define BMR_EXC_ADDR 8'h02
`define BMR_EXC_VALUE 8'h03
// Request PDU length in bytes and read quantity limit.
`define BMR_REQ_LEN 3'h5
`define BMR_MAX_QTY 16'h007D
// Holding register addresses of the setpoint pairs.
`define BMR_HOLD_PRI_C_A 16'h0000
`define BMR_HOLD_SHD_C 16'h0001
`define BMR_HOLD_PRI_F_A 16'h0002
`define BMR_HOLD_SHD_F 16'h0003
`define BMR_HOLD_AUX_C 16'h0031
`define BMR_HOLD_AUX_F 16'h0032
`define BMR_HOLD_PRI_C_B 16'h0094
`define BMR_HOLD_PRI_F_B 16'h0095
// Highest input register address (current temperatures 0 to 5).
`define BMR_INPUT_LAST 16'h0005
// Setpoint pair indices.
`define BMR_PAIR_PRI_A 2'h0
`define BMR_PAIR_SHD 2'h1
`define BMR_PAIR_AUX 2'h2
`define BMR_PAIR_PRI_B 2'h3
// Coil addresses.
`define BMR_COIL_AUX_A 16'h0000
`define BMR_COIL_AUX_B 16'h0001
`define BMR_COIL_STEP_FIRST 16'h0010
`define BMR_COIL_STOP 16'h0016
`define BMR_COIL_START 16'h0017
`define BMR_COIL_STEP_LAST 16'h0019
// Coil write values.
`define BMR_COIL_ON 16'hFF00
`define BMR_COIL_OFF 16'h0000
// Setpoint reset values and step size in degrees Celsius.
`define BMR_SP_RESET_C 16'h0000
`define BMR_SP_RESET_F 16'h0020
`define BMR_SP_STEP 16'h0001
// Celsius to Fahrenheit conversion constants.
`define BMR_CONV_MUL 9
`define BMR_CONV_DIV 5
`define BMR_CONV_OFS 32
// Number of shutdown loop inputs.
`define BMR_SD_COUNT 4
`endif

// ==== src/bmr_register_map.v ====
`timescale 1ns/1ps
`include "bmr_map.vh"
// Notes on behaviour
// - Holding reads return words, high byte first.
// - Setpoints at holding 0-3, 49-50, 148-149.
// - Input registers 0-5 return current temperatures.
// - Holding writes assemble high byte first.
// - Setpoint write updates converted paired unit, except auxiliary pair.
// - Coil values only 0xFF00 or 0x0000.
// - Off value changes no setpoint or run.
// - Step coils raise or lower setpoints.
// - Coil 22 on stops everything.
// - Coil 23 on permits switching on.
// - Remote start write clears remote stop.
// - Input toggle or stop-start buttons clear stop.
// - Remote stop write cancels remote start.
// - Open permissive inputs interrupt remote start.
// - Auxiliary relay coils need Modbus control selection.
// - Coils 2 to 15 refuse writes.
module bmr_register_map (
  // Clock and reset.
  input wire MCLK,
  input wire RSTN,
  // Request PDU byte stream, framing already removed.
  input wire REQ_VALID,
  input wire [7:0] REQ_DATA,
  input wire REQ_LAST,
  output wire REQ_READY,
  // Response PDU byte stream.
  output wire RSP_VALID,
  output wire [7:0] RSP_DATA,
  output wire RSP_LAST,
  input wire RSP_READY,
  // Current temperatures from the measurement logic.
  input wire [15:0] PRIMARY_TEMP_C,
  input wire [15:0] SHUTDOWN_TEMP_C,
  input wire [15:0] PRIMARY_TEMP_F,
  input wire [15:0] SHUTDOWN_TEMP_F,
  input wire [15:0] AUXILIARY_TEMP_C,
  input wire [15:0] AUXILIARY_TEMP_F,
  // Relay control selections for the auxiliary relays.
  input wire AUX_A_MODBUS_SEL,
  input wire AUX_B_MODBUS_SEL,
  // Field pins, closed or released reads as one.
  input wire REMOTE_RUN_CLOSED,
  input wire AIR_PROOF_CLOSED,
  input wire [`BMR_SD_COUNT-1:0] SHUTDOWN_CLOSED,
  input wire STOP_BUTTON_N,
  input wire START_BUTTON_N,
  // Run state and relay outputs.
  output reg REMOTE_STOP,
  output reg REMOTE_START,
  output reg RUN_PERMIT,
  output reg AUX_RELAY_A,
  output reg AUX_RELAY_B,
  // Setpoints for the burner sequencing logic.
  output wire [15:0] PRIMARY_SETPOINT_C_A,
  output wire [15:0] SHUTDOWN_SETPOINT_C,
  output wire [15:0] AUXILIARY_SETPOINT_C,
  output wire [15:0] PRIMARY_SETPOINT_C_B
);

  localparam S_RX = 2'h0;
  localparam S_EXEC = 2'h1;
  localparam S_CHECK = 2'h2;
  localparam S_SEND = 2'h3;
  localparam PW = `BMR_SD_COUNT + 4;
  // Decodes a holding address to {valid, fahrenheit, pair}.
  function [3:0] hold_dec;
    input [15:0] a;
    begin
      case (a)
        `BMR_HOLD_PRI_C_A: hold_dec = {2'b10, `BMR_PAIR_PRI_A};
        `BMR_HOLD_SHD_C: hold_dec = {2'b10, `BMR_PAIR_SHD};
        `BMR_HOLD_PRI_F_A: hold_dec = {2'b11, `BMR_PAIR_PRI_A};
        `BMR_HOLD_SHD_F: hold_dec = {2'b11, `BMR_PAIR_SHD};
        `BMR_HOLD_AUX_C: hold_dec = {2'b10, `BMR_PAIR_AUX};
        `BMR_HOLD_AUX_F: hold_dec = {2'b11, `BMR_PAIR_AUX};
        `BMR_HOLD_PRI_C_B: hold_dec = {2'b10, `BMR_PAIR_PRI_B};
        `BMR_HOLD_PRI_F_B: hold_dec = {2'b11, `BMR_PAIR_PRI_B};
        default: hold_dec = 4'h0;
      endcase
    end
  endfunction
  // Converts Celsius to Fahrenheit, truncating toward zero.
  function [15:0] c_to_f;
    input [15:0] c;
    reg signed [31:0] t;
    begin
      t = $signed(c) * `BMR_CONV_MUL / `BMR_CONV_DIV + `BMR_CONV_OFS;
      c_to_f = t[15:0];
    end
  endfunction
  // Converts Fahrenheit to Celsius, truncating toward zero.
  function [15:0] f_to_c;
    input [15:0] f;
    reg signed [31:0] t;
    begin
      t = ($signed(f) - `BMR_CONV_OFS) * `BMR_CONV_DIV / `BMR_CONV_MUL;
      f_to_c = t[15:0];
    end
  endfunction
  reg [1:0] state_q; // Request engine state.
  reg [7:0] rx_q [0:4]; // Received PDU bytes.
  reg [2:0] rx_cnt_q; // Bytes received, saturating above the PDU length.
  reg [15:0] sp_c_q [0:3]; // Celsius setpoints per pair.
  reg [15:0] sp_f_q [0:3]; // Fahrenheit setpoints per pair.
  reg [7:0] exc_q; // Exception code, zero when none.
  reg echo_q; // Answer is an echo of the request.
  reg [7:0] chk_q; // Address offset under check for reads.
  reg [7:0] sidx_q; // Index of the byte now presented.
  reg [7:0] rsp_q; // Registered response byte.
  reg rsp_v_q; // Response byte valid.
  reg [PW-1:0] meta_q; // First synchroniser stage, read only by sync_q.
  reg [PW-1:0] sync_q; // Second synchroniser stage.
  reg run_prev_q; // Previous remote run level, for toggle detection.
  reg stop_prev_q; // Previous stop button level.
  reg start_prev_q; // Previous start button level.
  reg stop_armed_q; // Stop button seen since the last start press.
  reg [7:0] bidx; // Index of the byte being built.
  reg [7:0] bval; // Byte being built.
  reg [15:0] word; // Register word for a read byte.
  reg [3:0] dec; // Decoded read address.
  reg [15:0] raddr; // Address of the word being sent.
  integer i;
  // Request fields, always taken high byte first.
  wire [7:0] func = rx_q[0];
  wire [15:0] addr = {rx_q[1], rx_q[2]};
  wire [15:0] val = {rx_q[3], rx_q[4]};
  wire [3:0] wdec = hold_dec(addr);
  wire [15:0] caddr = addr + {8'h00, chk_q};
  wire [3:0] cdec = hold_dec(caddr); // Decoded address under check.
  wire is_hold = (func == `BMR_FC_READ_HOLD);
  wire [7:0] rlen = echo_q ? 8'h05 : (exc_q != 8'h00) ? 8'h02 : {val[6:0], 1'b0} + 8'h02;
  wire coil_on = (val == `BMR_COIL_ON);
  wire [15:0] coil_ofs = addr - `BMR_COIL_STEP_FIRST;
  wire [1:0] step_pair = coil_ofs[3] ? 2'h3 : coil_ofs[2:1]; // Coils 24 and 25 use the last pair.
  wire step_up = ~coil_ofs[0];
  // Synchronised pins.
  wire run_s = sync_q[0];
  wire air_s = sync_q[1];
  wire stop_n_s = sync_q[2];
  wire start_n_s = sync_q[3];
  wire sd_ok_s = &sync_q[PW-1:4];

  assign REQ_READY = (state_q == S_RX);
  assign RSP_VALID = rsp_v_q;
  assign RSP_DATA = rsp_q;
  assign RSP_LAST = rsp_v_q && (sidx_q == rlen - 8'h01);
  assign PRIMARY_SETPOINT_C_A = sp_c_q[`BMR_PAIR_PRI_A];
  assign SHUTDOWN_SETPOINT_C = sp_c_q[`BMR_PAIR_SHD];
  assign AUXILIARY_SETPOINT_C = sp_c_q[`BMR_PAIR_AUX];
  assign PRIMARY_SETPOINT_C_B = sp_c_q[`BMR_PAIR_PRI_B];

  // Pins cross through two flip-flops; buttons reset released, so no false press follows.
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      meta_q <= {{`BMR_SD_COUNT{1'b0}}, 4'hC};
      sync_q <= {{`BMR_SD_COUNT{1'b0}}, 4'hC};
    end else begin
      meta_q <= {SHUTDOWN_CLOSED, START_BUTTON_N, STOP_BUTTON_N, AIR_PROOF_CLOSED,
                 REMOTE_RUN_CLOSED};
      sync_q <= meta_q;
    end
  end

  // Builds the next response byte; read data goes out high byte first.
  always @* begin
    bidx = (state_q == S_SEND && rsp_v_q) ? sidx_q + 8'h01 : 8'h00;
    raddr = addr + {9'h000, bidx[7:1]} - 16'h0001;
    dec = hold_dec(raddr);
    word = 16'h0000;
    if (is_hold) begin
      word = dec[2] ? sp_f_q[dec[1:0]] : sp_c_q[dec[1:0]];
    end else begin
      case (raddr[2:0])
        3'h0: word = PRIMARY_TEMP_C;
        3'h1: word = SHUTDOWN_TEMP_C;
        3'h2: word = PRIMARY_TEMP_F;
        3'h3: word = SHUTDOWN_TEMP_F;
        3'h4: word = AUXILIARY_TEMP_C;
        default: word = AUXILIARY_TEMP_F;
      endcase
    end
    if (exc_q != 8'h00) begin
      bval = (bidx == 8'h00) ? (func | `BMR_FC_EXC_FLAG) : exc_q;
    end else if (echo_q) begin
      bval = rx_q[bidx[2:0]];
    end else if (bidx == 8'h00) begin
      bval = func;
    end else if (bidx == 8'h01) begin
      bval = {val[6:0], 1'b0};
    end else begin
      bval = bidx[0] ? word[7:0] : word[15:8];
    end
  end

  // Request engine, setpoint store and run state. Later assignments win,
  // so a coil write in the same cycle as a pin-driven clear takes effect.
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= S_RX;
      for (i = 0; i < 5; i = i + 1) begin
        rx_q[i] <= 8'h00;
      end
      for (i = 0; i < 4; i = i + 1) begin
        sp_c_q[i] <= `BMR_SP_RESET_C;
        sp_f_q[i] <= `BMR_SP_RESET_F;
      end
      rx_cnt_q <= 3'h0;
      exc_q <= 8'h00;
      echo_q <= 1'b0;
      chk_q <= 8'h00;
      sidx_q <= 8'h00;
      rsp_q <= 8'h00;
      rsp_v_q <= 1'b0;
      run_prev_q <= 1'b0;
      stop_prev_q <= 1'b1;
      start_prev_q <= 1'b1;
      stop_armed_q <= 1'b0;
      REMOTE_STOP <= 1'b0;
      REMOTE_START <= 1'b0;
      RUN_PERMIT <= 1'b0;
      AUX_RELAY_A <= 1'b0;
      AUX_RELAY_B <= 1'b0;
    end else begin
      run_prev_q <= run_s;
      stop_prev_q <= stop_n_s;
      start_prev_q <= start_n_s;
      // A toggle of the remote run loop releases a remote stop.
      if (run_s != run_prev_q) begin
        REMOTE_STOP <= 1'b0;
      end
      // Stop then start on the panel also releases it.
      if (stop_prev_q && !stop_n_s) begin
        stop_armed_q <= 1'b1;
      end
      if (start_prev_q && !start_n_s) begin
        stop_armed_q <= 1'b0;
        if (stop_armed_q) begin
          REMOTE_STOP <= 1'b0;
        end
      end
      case (state_q)
        // Collect one PDU; a wrong length is dropped without an answer.
        S_RX: begin
          if (REQ_VALID) begin
            if (rx_cnt_q < `BMR_REQ_LEN) begin
              rx_q[rx_cnt_q] <= REQ_DATA;
            end
            rx_cnt_q <= (rx_cnt_q > `BMR_REQ_LEN) ? rx_cnt_q : rx_cnt_q + 3'h1;
            if (REQ_LAST) begin
              rx_cnt_q <= 3'h0;
              if (rx_cnt_q == `BMR_REQ_LEN - 3'h1) begin
                state_q <= S_EXEC;
              end
            end
          end
        end
        // Carry out the request in one cycle.
        S_EXEC: begin
          exc_q <= 8'h00;
          echo_q <= 1'b0;
          chk_q <= 8'h00;
          state_q <= S_SEND;
          case (func)
            `BMR_FC_READ_HOLD, `BMR_FC_READ_INPUT: begin
              if (val == 16'h0000 || val > `BMR_MAX_QTY) begin
                exc_q <= `BMR_EXC_VALUE;
              end else begin
                state_q <= S_CHECK;
              end
            end
            `BMR_FC_WRITE_HOLD: begin
              echo_q <= wdec[3];
              if (!wdec[3]) begin
                exc_q <= `BMR_EXC_ADDR;
              end else if (!wdec[2]) begin
                sp_c_q[wdec[1:0]] <= val;
                if (wdec[1:0] != `BMR_PAIR_AUX) begin
                  sp_f_q[wdec[1:0]] <= c_to_f(val);
                end
              end else begin
                sp_f_q[wdec[1:0]] <= val;
                if (wdec[1:0] != `BMR_PAIR_AUX) begin
                  sp_c_q[wdec[1:0]] <= f_to_c(val);
                end
              end
            end
            `BMR_FC_WRITE_COIL: begin
              echo_q <= 1'b1;
              if (!coil_on && val != `BMR_COIL_OFF) begin
                echo_q <= 1'b0;
                exc_q <= `BMR_EXC_VALUE;
              end else if (addr == `BMR_COIL_AUX_A) begin
                if (AUX_A_MODBUS_SEL) begin
                  AUX_RELAY_A <= coil_on;
                end
              end else if (addr == `BMR_COIL_AUX_B) begin
                if (AUX_B_MODBUS_SEL) begin
                  AUX_RELAY_B <= coil_on;
                end
              end else if (addr == `BMR_COIL_STOP) begin
                if (coil_on) begin
                  REMOTE_STOP <= 1'b1;
                  REMOTE_START <= 1'b0;
                  AUX_RELAY_A <= 1'b0;
                  AUX_RELAY_B <= 1'b0;
                end
              end else if (addr == `BMR_COIL_START) begin
                if (coil_on) begin
                  REMOTE_START <= 1'b1;
                  REMOTE_STOP <= 1'b0;
                end
              end else if (addr >= `BMR_COIL_STEP_FIRST && addr <= `BMR_COIL_STEP_LAST) begin
                // The off value leaves setpoints alone.
                if (coil_on) begin
                  if (step_up) begin
                    sp_c_q[step_pair] <= sp_c_q[step_pair] + `BMR_SP_STEP;
                    sp_f_q[step_pair] <= c_to_f(sp_c_q[step_pair] + `BMR_SP_STEP);
                  end else begin
                    sp_c_q[step_pair] <= sp_c_q[step_pair] - `BMR_SP_STEP;
                    sp_f_q[step_pair] <= c_to_f(sp_c_q[step_pair] - `BMR_SP_STEP);
                  end
                end
              end else begin
                // Status-only coils and absent coils change nothing.
                echo_q <= 1'b0;
                exc_q <= `BMR_EXC_ADDR;
              end
            end
            default: begin
              exc_q <= `BMR_EXC_FUNC;
            end
          endcase
        end
        // Every address of a read must exist before any data is sent.
        S_CHECK: begin
          if ((is_hold && !cdec[3]) || (!is_hold && caddr > `BMR_INPUT_LAST)) begin
            exc_q <= `BMR_EXC_ADDR;
            state_q <= S_SEND;
          end else if ({8'h00, chk_q} == val - 16'h0001) begin
            state_q <= S_SEND;
          end
          chk_q <= chk_q + 8'h01;
        end
        // Present bytes one at a time, each held until taken.
        default: begin
          if (!rsp_v_q) begin
            rsp_v_q <= 1'b1;
            rsp_q <= bval;
            sidx_q <= 8'h00;
          end else if (RSP_READY) begin
            if (RSP_LAST) begin
              rsp_v_q <= 1'b0;
              state_q <= S_RX;
            end else begin
              rsp_q <= bval;
              sidx_q <= sidx_q + 8'h01;
            end
          end
        end
      endcase
      // Run is permitted only while every permissive loop is closed.
      RUN_PERMIT <= REMOTE_START && !REMOTE_STOP && run_s && air_s && sd_ok_s;
    end
  end
endmodule

// ==== testbench/bmr_master_model.sv ====
`timescale 1ns/1ps
// Plant controller side: one request at a time, answers collected with random stalls.
module bmr_master_model (
  // Clock.
  input wire clk,
  // Request stream.
  output reg req_valid,
  output reg [7:0] req_data,
  output reg req_last,
  input wire req_ready,
  // Response stream.
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  output reg rsp_ready
);
  reg [7:0] rsp_q [$]; // Bytes of the latest answer.
  initial begin
    req_valid = 1'b0;
    req_data = 8'h00;
    req_last = 1'b0;
    rsp_ready = 1'b0;
  end
  // Each byte is held until taken; the released data line shows junk, not the last byte.
  task xact(input [39:0] pdu);
    integer i;
    integer n;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        req_valid <= 1'b1;
        req_data <= pdu[39 - 8 * i -: 8];
        req_last <= (i == 4);
        @(posedge clk);
        while (!req_ready) @(posedge clk);
      end
      req_valid <= 1'b0;
      req_last <= 1'b0;
      req_data <= ~pdu[7:0];
      rsp_q = {};
      n = 0;
      while (n < 400) begin
        rsp_ready <= ($urandom % 3) != 0;
        @(posedge clk);
        n = n + 1;
        if (rsp_valid && rsp_ready) begin
          rsp_q.push_back(rsp_data);
          n = rsp_last ? 999 : n;
        end
      end
      rsp_ready <= 1'b0;
    end
  endtask
endmodule

// ==== testbench/bmr_register_map_sva.sv ====
`timescale 1ns/1ps
`include "bmr_map.vh"
// Watches run control, relays and request pacing of the register map.
module bmr_register_map_sva (
  // Clock and reset.
  input wire MCLK,
  input wire RSTN,
  // Request and response streams.
  input wire REQ_VALID,
  input wire REQ_LAST,
  input wire REQ_READY,
  input wire RSP_VALID,
  // Selections and field pins.
  input wire AUX_A_MODBUS_SEL,
  input wire AUX_B_MODBUS_SEL,
  input wire REMOTE_RUN_CLOSED,
  input wire AIR_PROOF_CLOSED,
  input wire [`BMR_SD_COUNT-1:0] SHUTDOWN_CLOSED,
  // Run state, relays and setpoints.
  input wire REMOTE_STOP,
  input wire REMOTE_START,
  input wire RUN_PERMIT,
  input wire AUX_RELAY_A,
  input wire AUX_RELAY_B,
  input wire [15:0] PRIMARY_SETPOINT_C_A,
  input wire [15:0] SHUTDOWN_SETPOINT_C,
  input wire [15:0] AUXILIARY_SETPOINT_C,
  input wire [15:0] PRIMARY_SETPOINT_C_B
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // The edge that takes the final request byte.
  sequence req_end;
    REQ_VALID && REQ_READY && REQ_LAST;
  endsequence
  // The longest legal read delays the answer by its quantity of check cycles.
  sequence rsp_begin;
    ##[1:127] RSP_VALID;
  endsequence
  answer_bound_a: assert property (req_end |=> !REQ_READY throughout rsp_begin)
    else $error("request left without an answer");
  start_cancel_a: assert property ($rose(REMOTE_STOP) |-> !REMOTE_START)
    else $error("remote start survived a remote stop");
  stop_relays_a: assert property (REMOTE_STOP && $past(REMOTE_STOP) |->
    !AUX_RELAY_A && !AUX_RELAY_B && !RUN_PERMIT) else $error("outputs live while stopped");
  permit_start_a: assert property (RUN_PERMIT |->
    $past(REMOTE_START) && !$past(REMOTE_STOP)) else $error("permit without remote start");
  // Pins pass two sync stages and the permit register, so three edges of latency.
  permit_pins_a: assert property (RUN_PERMIT |-> $past(AIR_PROOF_CLOSED, 3) &&
    $past(REMOTE_RUN_CLOSED, 3) && (&$past(SHUTDOWN_CLOSED, 3)))
    else $error("permit with an open loop");
  aux_a_sel_a: assert property ($rose(AUX_RELAY_A) |-> $past(AUX_A_MODBUS_SEL))
    else $error("first relay set without selection");
  aux_b_sel_a: assert property ($rose(AUX_RELAY_B) |-> $past(AUX_B_MODBUS_SEL))
    else $error("second relay set without selection");
  setpoint_quiet_a: assert property (!$stable({PRIMARY_SETPOINT_C_A,
    SHUTDOWN_SETPOINT_C, AUXILIARY_SETPOINT_C, PRIMARY_SETPOINT_C_B}) |-> !REQ_READY)
    else $error("setpoint moved outside a request");
endmodule
bind bmr_register_map bmr_register_map_sva chk_u (.MCLK, .RSTN, .REQ_VALID, .REQ_LAST,
  .REQ_READY, .RSP_VALID, .AUX_A_MODBUS_SEL, .AUX_B_MODBUS_SEL, .REMOTE_RUN_CLOSED,
  .AIR_PROOF_CLOSED, .SHUTDOWN_CLOSED, .REMOTE_STOP, .REMOTE_START, .RUN_PERMIT,
  .AUX_RELAY_A, .AUX_RELAY_B, .PRIMARY_SETPOINT_C_A, .SHUTDOWN_SETPOINT_C,
  .AUXILIARY_SETPOINT_C, .PRIMARY_SETPOINT_C_B);

// ==== testbench/bmr_register_map_tb.sv ====
`timescale 1ns/1ps
`include "bmr_map.vh"
module bmr_register_map_tb;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg [15:0] tmp [0:5]; // Current temperatures fed in.
  reg sel_a = 1'b0;
  reg sel_b = 1'b0;
  reg run_cl = 1'b1; // Loops start closed, buttons released.
  reg air_cl = 1'b1;
  reg [3:0] sd_cl = 4'hF;
  reg stop_n = 1'b1;
  reg start_n = 1'b1;
  wire req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  wire [7:0] req_data, rsp_data;
  wire r_stop, r_start, permit, aux_a, aux_b;
  wire [15:0] sp_c [0:3];
  reg [15:0] ce [0:3]; // Expected setpoints per pair, Celsius and Fahrenheit.
  reg [15:0] fe [0:3];
  reg [7:0] exp_q [$];
  integer failures = 0;
  integer checked = 0;
  integer cycles = 0;
  integer k;
  reg [15:0] v;
  reg [15:0] a;
  localparam logic [15:0] CA [4] = '{`BMR_HOLD_PRI_C_A, `BMR_HOLD_SHD_C, `BMR_HOLD_AUX_C,
    `BMR_HOLD_PRI_C_B};
  localparam logic [15:0] FA [4] = '{`BMR_HOLD_PRI_F_A, `BMR_HOLD_SHD_F, `BMR_HOLD_AUX_F,
    `BMR_HOLD_PRI_F_B};
  bmr_register_map dut_u (.MCLK(mclk), .RSTN(rstn), .REQ_VALID(req_valid),
    .REQ_DATA(req_data), .REQ_LAST(req_last), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .RSP_READY(rsp_ready),
    .PRIMARY_TEMP_C(tmp[0]), .SHUTDOWN_TEMP_C(tmp[1]), .PRIMARY_TEMP_F(tmp[2]),
    .SHUTDOWN_TEMP_F(tmp[3]), .AUXILIARY_TEMP_C(tmp[4]), .AUXILIARY_TEMP_F(tmp[5]),
    .AUX_A_MODBUS_SEL(sel_a), .AUX_B_MODBUS_SEL(sel_b), .REMOTE_RUN_CLOSED(run_cl),
    .AIR_PROOF_CLOSED(air_cl), .SHUTDOWN_CLOSED(sd_cl), .STOP_BUTTON_N(stop_n),
    .START_BUTTON_N(start_n), .REMOTE_STOP(r_stop), .REMOTE_START(r_start),
    .RUN_PERMIT(permit), .AUX_RELAY_A(aux_a), .AUX_RELAY_B(aux_b),
    .PRIMARY_SETPOINT_C_A(sp_c[0]), .SHUTDOWN_SETPOINT_C(sp_c[1]),
    .AUXILIARY_SETPOINT_C(sp_c[2]), .PRIMARY_SETPOINT_C_B(sp_c[3]));
  bmr_master_model mm_u (.clk(mclk), .req_valid(req_valid), .req_data(req_data),
    .req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Signed conversions truncate toward zero, as the map does.
  function [15:0] c2f(input [15:0] c);
    c2f = 16'($signed(c) * 9 / 5 + 32);
  endfunction
  function [15:0] f2c(input [15:0] f);
    f2c = 16'(($signed(f) - 32) * 5 / 9);
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_rsp;
    integer i;
    begin
      chk(16'(mm_u.rsp_q.size()), 16'(exp_q.size()));
      for (i = 0; i < exp_q.size() && i < mm_u.rsp_q.size(); i = i + 1)
        chk({8'h00, mm_u.rsp_q[i]}, {8'h00, exp_q[i]});
    end
  endtask
  // A good write answers with an echo of the request.
  task echo(input [7:0] fc, input [15:0] ad, input [15:0] va);
    begin
      mm_u.xact({fc, ad, va});
      exp_q = '{fc, ad[15:8], ad[7:0], va[15:8], va[7:0]};
      cmp_rsp;
    end
  endtask
  task exc(input [7:0] fc, input [15:0] ad, input [15:0] va, input [7:0] code);
    begin
      mm_u.xact({fc, ad, va});
      exp_q = '{fc | 8'h80, code};
      cmp_rsp;
    end
  endtask
  task rd_hold(input [15:0] ad, input [15:0] ex);
    begin
      mm_u.xact({8'h03, ad, 16'h0001});
      exp_q = '{8'h03, 8'h02, ex[15:8], ex[7:0]};
      cmp_rsp;
    end
  endtask
  task pair_chk(input integer p);
    begin
      rd_hold(CA[p], ce[p]);
      rd_hold(FA[p], fe[p]);
      chk(sp_c[p], ce[p]);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // A hung handshake counts as a mismatch.
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    for (k = 0; k < 6; k = k + 1)
      tmp[k] = 16'h0000;
    for (k = 0; k < 4; k = k + 1) begin
      ce[k] = `BMR_SP_RESET_C;
      fe[k] = `BMR_SP_RESET_F;
    end
    void'($urandom(32'h6c5146fd));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    // The auxiliary pair has no conversion on direct writes.
    for (k = 0; k < 4; k = k + 1) begin
      pair_chk(k);
      v = (k == 0) ? 16'hFFD8 : 16'($urandom % 600);
      echo(8'h06, CA[k], v);
      ce[k] = v;
      fe[k] = (k == 2) ? fe[k] : c2f(v);
      pair_chk(k);
      v = 16'(32 + $urandom % 900);
      echo(8'h06, FA[k], v);
      fe[k] = v;
      ce[k] = (k == 2) ? ce[k] : f2c(v);
      pair_chk(k);
    end
    $display("test setpoint writes done");
    for (k = 0; k < 4; k = k + 1) begin
      a = (k == 3) ? 16'd24 : 16'(16 + 2 * k);
      echo(8'h05, a, `BMR_COIL_OFF);
      echo(8'h05, a + 16'd1, `BMR_COIL_OFF);
      pair_chk(k);
      echo(8'h05, a, `BMR_COIL_ON);
      ce[k] = ce[k] + 16'd1;
      fe[k] = c2f(ce[k]);
      pair_chk(k);
      echo(8'h05, a + 16'd1, `BMR_COIL_ON);
      echo(8'h05, a + 16'd1, `BMR_COIL_ON);
      ce[k] = ce[k] - 16'd2;
      fe[k] = c2f(ce[k]);
      pair_chk(k);
    end
    $display("test step coils done");
    for (k = 0; k < 6; k = k + 1)
      tmp[k] <= 16'($urandom);
    mm_u.xact({8'h04, 16'h0000, 16'h0006});
    exp_q = '{8'h04, 8'h0C};
    for (k = 0; k < 6; k = k + 1) begin
      exp_q.push_back(tmp[k][15:8]);
      exp_q.push_back(tmp[k][7:0]);
    end
    cmp_rsp;
    exc(8'h04, 16'h0006, 16'h0001, `BMR_EXC_ADDR);
    exc(8'h06, 16'h0004, 16'h0001, `BMR_EXC_ADDR);
    exc(8'h05, 16'(2 + $urandom % 14), `BMR_COIL_ON, `BMR_EXC_ADDR);
    exc(8'h05, `BMR_COIL_STOP, 16'h1234, `BMR_EXC_VALUE);
    exc(8'h01, 16'h0000, 16'h0001, `BMR_EXC_FUNC);
    exc(8'h03, 16'h0000, 16'h0000, `BMR_EXC_VALUE);
    exc(8'h03, `BMR_HOLD_SHD_F, 16'h0002, `BMR_EXC_ADDR);
    chk({aux_a, aux_b, r_stop}, 3'b000);
    pair_chk(0);
    $display("test reads and refusals done");
    echo(8'h05, `BMR_COIL_START, `BMR_COIL_OFF);
    chk(r_start, 1'b0);
    echo(8'h05, `BMR_COIL_START, `BMR_COIL_ON);
    chk({r_start, permit}, 2'b11);
    echo(8'h05, `BMR_COIL_AUX_A, `BMR_COIL_ON);
    sel_b <= 1'b1;
    echo(8'h05, `BMR_COIL_AUX_B, `BMR_COIL_ON);
    chk({aux_a, aux_b}, 2'b01);
    sel_a <= 1'b1;
    echo(8'h05, `BMR_COIL_AUX_A, `BMR_COIL_ON);
    chk({aux_a, aux_b}, 2'b11);
    echo(8'h05, `BMR_COIL_STOP, `BMR_COIL_OFF);
    chk(r_stop, 1'b0);
    echo(8'h05, `BMR_COIL_STOP, `BMR_COIL_ON);
    chk({r_stop, r_start, permit, aux_a, aux_b}, 5'b10000);
    echo(8'h05, `BMR_COIL_START, `BMR_COIL_ON);
    chk({r_stop, r_start}, 2'b01);
    echo(8'h05, `BMR_COIL_STOP, `BMR_COIL_ON);
    run_cl <= 1'b0;
    repeat (4) @(posedge mclk);
    run_cl <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(r_stop, 1'b0);
    echo(8'h05, `BMR_COIL_STOP, `BMR_COIL_ON);
    stop_n <= 1'b0;
    repeat (4) @(posedge mclk);
    stop_n <= 1'b1;
    start_n <= 1'b0;
    repeat (4) @(posedge mclk);
    start_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(r_stop, 1'b0);
    echo(8'h05, `BMR_COIL_START, `BMR_COIL_ON);
    // Open each kind of permissive loop in turn, then close it again.
    for (k = 0; k < 3; k = k + 1) begin
      air_cl <= (k != 0);
      sd_cl <= (k == 1) ? ~(4'h1 << ($urandom % 4)) : 4'hF;
      run_cl <= (k != 2);
      repeat (4) @(posedge mclk);
      chk(permit, 1'b0);
      air_cl <= 1'b1;
      sd_cl <= 4'hF;
      run_cl <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({r_start, permit}, 2'b11);
    end
    $display("test run control done");
    end_of_test;
  end
endmodule
